//--- core/emb_mult_top.sv
// Purpose: Embedded multiplier with optional in/out registers, AXI4-Lite setup.
// Assumes: Operands and sign pins come from logic on i_clk; no synchroniser.
// Notes:   Sums and accumulations belong to the surrounding logic.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module emb_mult_top
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_aclr,
  input  wire logic        i_clk_en,
  input  wire logic [17:0] i_op_a,
  input  wire logic [17:0] i_op_b,
  input  wire logic        i_sign_a,
  input  wire logic        i_sign_b,
  output logic      [35:0] o_product,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready
);

  // Bus side state
  logic        aw_hold_r;
  logic        aw_hold_nxt;
  logic [7:0]  awaddr_r;
  logic [7:0]  awaddr_nxt;
  logic        w_hold_r;
  logic        w_hold_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic [3:0]  wstrb_r;
  logic [3:0]  wstrb_nxt;
  logic        awready_r;
  logic        awready_nxt;
  logic        wready_r;
  logic        wready_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;
  logic        arready_r;
  logic        arready_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_r;
  logic [1:0]  rresp_nxt;

  // Configuration and software operands
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] opa_r;
  logic [31:0] opa_nxt;
  logic [31:0] opb_r;
  logic [31:0] opb_nxt;

  // Datapath
  logic               sign_a_eff;
  logic               sign_b_eff;
  logic [17:0]        src_a;
  logic [17:0]        src_b;
  logic [17:0]        in_a_r;
  logic [17:0]        in_a_nxt;
  logic [17:0]        in_b_r;
  logic [17:0]        in_b_nxt;
  logic               in_sa_r;
  logic               in_sa_nxt;
  logic               in_sb_r;
  logic               in_sb_nxt;
  logic [17:0]        mul_a;
  logic [17:0]        mul_b;
  logic               mul_sa;
  logic               mul_sb;
  emb_pkg::emb_mode_t mode;
  logic [35:0]        prod_comb;
  logic [17:0]        sect_r   [emb_pkg::EMB_NSECT];
  logic [17:0]        sect_nxt [emb_pkg::EMB_NSECT];
  logic [35:0]        sect_word;
  logic [31:0]        status_word;
  logic               wr_fire;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < emb_pkg::EMB_AXI_SW; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return res;
  endfunction

  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;

  // Write channels: address and data taken in either order
  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    awaddr_nxt  = awaddr_r;
    w_hold_nxt  = w_hold_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    opa_nxt     = opa_r;
    opb_nxt     = opb_r;
    if (i_s_axi_awvalid && awready_r)
    begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && wready_r)
    begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = i_s_axi_wdata;
      wstrb_nxt  = i_s_axi_wstrb;
    end
    if (bvalid_r && i_s_axi_bready)
      bvalid_nxt = 1'b0;
    if (wr_fire)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = emb_pkg::EMB_RESP_OKAY;
      case (awaddr_r)
        emb_pkg::EMB_OFF_CTRL:
          ctrl_nxt = merge_strb(ctrl_r, wdata_r, wstrb_r) & emb_pkg::EMB_CTRL_MASK;
        emb_pkg::EMB_OFF_OPA:
          opa_nxt = merge_strb(opa_r, wdata_r, wstrb_r) & emb_pkg::EMB_OPER_MASK;
        emb_pkg::EMB_OFF_OPB:
          opb_nxt = merge_strb(opb_r, wdata_r, wstrb_r) & emb_pkg::EMB_OPER_MASK;
        emb_pkg::EMB_OFF_RES_LO,
        emb_pkg::EMB_OFF_RES_HI,
        emb_pkg::EMB_OFF_STATUS:
          bresp_nxt = emb_pkg::EMB_RESP_OKAY; // Read-only, write dropped
        default:
          bresp_nxt = emb_pkg::EMB_RESP_SLVERR;
      endcase
    end
    // Ready only while the channel has room and no response waits
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt  = !w_hold_nxt && !bvalid_nxt;
    if (i_sys_rst)
    begin
      aw_hold_nxt = 1'b0;
      awaddr_nxt  = 8'h00;
      w_hold_nxt  = 1'b0;
      wdata_nxt   = emb_pkg::EMB_ZERO_WORD;
      wstrb_nxt   = 4'h0;
      bvalid_nxt  = 1'b0;
      bresp_nxt   = emb_pkg::EMB_RESP_OKAY;
      ctrl_nxt    = emb_pkg::EMB_CTRL_RST; // [RULE5]
      opa_nxt     = emb_pkg::EMB_ZERO_WORD;
      opb_nxt     = emb_pkg::EMB_ZERO_WORD;
      awready_nxt = 1'b0;
      wready_nxt  = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    aw_hold_r <= aw_hold_nxt;
    awaddr_r  <= awaddr_nxt;
    w_hold_r  <= w_hold_nxt;
    wdata_r   <= wdata_nxt;
    wstrb_r   <= wstrb_nxt;
    bvalid_r  <= bvalid_nxt;
    bresp_r   <= bresp_nxt;
    ctrl_r    <= ctrl_nxt;
    opa_r     <= opa_nxt;
    opb_r     <= opb_nxt;
    awready_r <= awready_nxt;
    wready_r  <= wready_nxt;
  end

  // Status view of the live configuration
  always_comb
  begin
    status_word = emb_pkg::EMB_ZERO_WORD;
    status_word[emb_pkg::EMB_STAT_DUAL]   = ctrl_r[emb_pkg::EMB_CTRL_DUAL];
    status_word[emb_pkg::EMB_STAT_SIGN_A] = mul_sa;
    status_word[emb_pkg::EMB_STAT_SIGN_B] = mul_sb;
    status_word[emb_pkg::EMB_STAT_IN_REG] = ctrl_r[emb_pkg::EMB_CTRL_IN_REG];
    status_word[emb_pkg::EMB_STAT_OUTREG] = ctrl_r[emb_pkg::EMB_CTRL_OUTREG];
  end

  // Read channel: one outstanding read, answered the next cycle
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && i_s_axi_rready)
      rvalid_nxt = 1'b0;
    if (i_s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = emb_pkg::EMB_RESP_OKAY;
      case (i_s_axi_araddr)
        emb_pkg::EMB_OFF_CTRL:   rdata_nxt = ctrl_r;
        emb_pkg::EMB_OFF_OPA:    rdata_nxt = opa_r;
        emb_pkg::EMB_OFF_OPB:    rdata_nxt = opb_r;
        emb_pkg::EMB_OFF_RES_LO: rdata_nxt = o_product[31:0];
        emb_pkg::EMB_OFF_RES_HI: rdata_nxt = {28'h0000000, o_product[35:32]};
        emb_pkg::EMB_OFF_STATUS: rdata_nxt = status_word;
        default:
        begin
          rdata_nxt = emb_pkg::EMB_ZERO_WORD;
          rresp_nxt = emb_pkg::EMB_RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
    if (i_sys_rst)
    begin
      rvalid_nxt  = 1'b0;
      rdata_nxt   = emb_pkg::EMB_ZERO_WORD;
      rresp_nxt   = emb_pkg::EMB_RESP_OKAY;
      arready_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    rvalid_r  <= rvalid_nxt;
    rdata_r   <= rdata_nxt;
    rresp_r   <= rresp_nxt;
    arready_r <= arready_nxt;
  end

  // Operand source and effective sign; pins low and bits clear mean unsigned
  always_comb
  begin
    sign_a_eff = i_sign_a | ctrl_r[emb_pkg::EMB_CTRL_SIGN_A]; // [RULE5] [RULE7]
    sign_b_eff = i_sign_b | ctrl_r[emb_pkg::EMB_CTRL_SIGN_B]; // [RULE5] [RULE7]
    src_a = ctrl_r[emb_pkg::EMB_CTRL_SW_OPS] ? opa_r[17:0] : i_op_a;
    src_b = ctrl_r[emb_pkg::EMB_CTRL_SW_OPS] ? opb_r[17:0] : i_op_b;
    mode  = emb_pkg::emb_mode_t'(ctrl_r[emb_pkg::EMB_CTRL_DUAL]); // [RULE4]
  end

  // Input registers: same clock, enable and clear as the output side
  always_comb
  begin
    in_a_nxt  = in_a_r;
    in_b_nxt  = in_b_r;
    in_sa_nxt = in_sa_r;
    in_sb_nxt = in_sb_r;
    if (i_clk_en) // [RULE3]
    begin
      in_a_nxt  = src_a;
      in_b_nxt  = src_b;
      in_sa_nxt = sign_a_eff;
      in_sb_nxt = sign_b_eff;
    end
    if (i_sys_rst)
    begin
      in_a_nxt  = 18'h00000;
      in_b_nxt  = 18'h00000;
      in_sa_nxt = 1'b0;
      in_sb_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_aclr)
  begin
    if (i_aclr) // [RULE3]
    begin
      in_a_r  <= 18'h00000;
      in_b_r  <= 18'h00000;
      in_sa_r <= 1'b0;
      in_sb_r <= 1'b0;
    end
    else
    begin
      in_a_r  <= in_a_nxt;
      in_b_r  <= in_b_nxt;
      in_sa_r <= in_sa_nxt;
      in_sb_r <= in_sb_nxt;
    end
  end

  // Bypass of the input stage adds no latency
  always_comb
  begin
    if (ctrl_r[emb_pkg::EMB_CTRL_IN_REG])
    begin
      mul_a  = in_a_r;
      mul_b  = in_b_r;
      mul_sa = in_sa_r;
      mul_sb = in_sb_r;
    end
    else
    begin
      mul_a  = src_a;
      mul_b  = src_b;
      mul_sa = sign_a_eff;
      mul_sb = sign_b_eff;
    end
  end

  emb_mult_core u_core
  (
    .i_op_a    (mul_a),
    .i_op_b    (mul_b),
    .i_sign_a  (mul_sa),
    .i_sign_b  (mul_sb),
    .i_mode    (mode),
    .o_product (prod_comb)
  );

  // Output sections, one per 18-bit lane; wide mode loads both together
  genvar s;
  generate
    for (s = 0; s < emb_pkg::EMB_NSECT; s++)
    begin : g_sect
      always_comb
      begin
        sect_nxt[s] = sect_r[s];
        if (i_clk_en) // [RULE2] [RULE3]
          sect_nxt[s] = prod_comb[s*emb_pkg::EMB_SECT_W +: emb_pkg::EMB_SECT_W]; // [RULE1]
        if (i_sys_rst)
          sect_nxt[s] = 18'h00000;
      end

      // Clear acts without the clock, hence outside the next-value logic
      always_ff @(posedge i_clk or posedge i_aclr)
      begin
        if (i_aclr) // [RULE2]
          sect_r[s] <= 18'h00000;
        else
          sect_r[s] <= sect_nxt[s];
      end
    end
  endgenerate

  assign sect_word = {sect_r[1], sect_r[0]};

  // Bypassed output stage is combinational by definition of the mode
  assign o_product = ctrl_r[emb_pkg::EMB_CTRL_OUTREG] ? sect_word : prod_comb; // [RULE1]

  assign o_s_axi_awready = awready_r;
  assign o_s_axi_wready  = wready_r;
  assign o_s_axi_bvalid  = bvalid_r;
  assign o_s_axi_bresp   = bresp_r;
  assign o_s_axi_arready = arready_r;
  assign o_s_axi_rvalid  = rvalid_r;
  assign o_s_axi_rdata   = rdata_r;
  assign o_s_axi_rresp   = rresp_r;

endmodule
`default_nettype wire

//--- pkg/emb_pkg.sv
// Purpose: Shared constants and types for the embedded multiplier block.
// Assumes: AXI4-Lite register access, 32-bit data, one clock.
// Notes:   Every offset, field position and width used by core/ lives here.
//
// Overview of operation
// [RULE1] Product optionally registered in 18/36-bit sections.
// [RULE2] Output registers take clock, enable, async clear.
// [RULE3] All in/out registers share clock, enable, clear.
// [RULE4] One 18x18 or two independent 9x9 multipliers.
// [RULE5] Unused sign controls mean unsigned operation.
// [RULE6] Adding or accumulating products is done outside.
// [RULE7] Asserted sign control means two's-complement operand.
`default_nettype none
package emb_pkg;

  // Datapath widths
  localparam int unsigned EMB_WIDE_W   = 18;
  localparam int unsigned EMB_NARROW_W = 9;
  localparam int unsigned EMB_PROD_W   = 36;
  localparam int unsigned EMB_SECT_W   = 18;
  localparam int unsigned EMB_NSECT    = 2;
  localparam int unsigned EMB_NLANE    = 2;

  // Register bus widths
  localparam int unsigned EMB_AXI_AW = 8;
  localparam int unsigned EMB_AXI_DW = 32;
  localparam int unsigned EMB_AXI_SW = 4;

  // Register byte offsets
  localparam logic [7:0] EMB_OFF_CTRL   = 8'h00;
  localparam logic [7:0] EMB_OFF_OPA    = 8'h04;
  localparam logic [7:0] EMB_OFF_OPB    = 8'h08;
  localparam logic [7:0] EMB_OFF_RES_LO = 8'h0C;
  localparam logic [7:0] EMB_OFF_RES_HI = 8'h10;
  localparam logic [7:0] EMB_OFF_STATUS = 8'h14;

  // Control register fields
  localparam int unsigned EMB_CTRL_DUAL   = 0;
  localparam int unsigned EMB_CTRL_SIGN_A = 1;
  localparam int unsigned EMB_CTRL_SIGN_B = 2;
  localparam int unsigned EMB_CTRL_IN_REG = 3;
  localparam int unsigned EMB_CTRL_OUTREG = 4;
  localparam int unsigned EMB_CTRL_SW_OPS = 5;
  localparam logic [31:0] EMB_CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] EMB_CTRL_MASK   = 32'h0000_003F;
  localparam logic [31:0] EMB_OPER_MASK   = 32'h0003_FFFF;
  localparam logic [31:0] EMB_ZERO_WORD   = 32'h0000_0000;

  // Status register fields
  localparam int unsigned EMB_STAT_DUAL   = 0;
  localparam int unsigned EMB_STAT_SIGN_A = 1;
  localparam int unsigned EMB_STAT_SIGN_B = 2;
  localparam int unsigned EMB_STAT_IN_REG = 3;
  localparam int unsigned EMB_STAT_OUTREG = 4;

  // AXI responses
  localparam logic [1:0] EMB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] EMB_RESP_SLVERR = 2'h2;

  // Operating mode
  typedef enum logic [0:0] {
    EMB_MODE_WIDE = 1'b0,
    EMB_MODE_DUAL = 1'b1
  } emb_mode_t;

endpackage
`default_nettype wire

//--- core/emb_mult_core.sv
// Purpose: Combinational product of one 18x18 or two 9x9 operand pairs.
// Assumes: Operands already selected and optionally registered upstream.
// Notes:   Sign bit is extended only when the lane's sign control is set.
`timescale 1ns/100ps
`default_nettype none
module emb_mult_core
(
  input  wire logic [17:0]          i_op_a,
  input  wire logic [17:0]          i_op_b,
  input  wire logic                 i_sign_a,
  input  wire logic                 i_sign_b,
  input  wire emb_pkg::emb_mode_t   i_mode,
  output logic      [35:0]          o_product
);

  logic signed [18:0] wide_a;
  logic signed [18:0] wide_b;
  logic signed [37:0] wide_p;
  logic signed [9:0]  lane_a [emb_pkg::EMB_NLANE];
  logic signed [9:0]  lane_b [emb_pkg::EMB_NLANE];
  logic signed [19:0] lane_p [emb_pkg::EMB_NLANE];

  // Wide multiplier, extension bit zero when unsigned
  always_comb
  begin
    wide_a = {i_sign_a & i_op_a[emb_pkg::EMB_WIDE_W-1], i_op_a}; // [RULE5] [RULE7]
    wide_b = {i_sign_b & i_op_b[emb_pkg::EMB_WIDE_W-1], i_op_b}; // [RULE5] [RULE7]
    wide_p = wide_a * wide_b;
  end

  // Two narrow lanes on the low and high operand halves
  genvar g;
  generate
    for (g = 0; g < emb_pkg::EMB_NLANE; g++)
    begin : g_lane
      always_comb
      begin
        lane_a[g] = {i_sign_a & i_op_a[g*emb_pkg::EMB_NARROW_W + emb_pkg::EMB_NARROW_W-1],
                     i_op_a[g*emb_pkg::EMB_NARROW_W +: emb_pkg::EMB_NARROW_W]}; // [RULE7]
        lane_b[g] = {i_sign_b & i_op_b[g*emb_pkg::EMB_NARROW_W + emb_pkg::EMB_NARROW_W-1],
                     i_op_b[g*emb_pkg::EMB_NARROW_W +: emb_pkg::EMB_NARROW_W]}; // [RULE7]
        lane_p[g] = lane_a[g] * lane_b[g];
      end
    end
  endgenerate

  // Mode select; lanes never interact in dual mode
  always_comb
  begin
    if (i_mode == emb_pkg::EMB_MODE_DUAL) // [RULE4]
      o_product = {lane_p[1][emb_pkg::EMB_SECT_W-1:0], lane_p[0][emb_pkg::EMB_SECT_W-1:0]};
    else
      o_product = wide_p[emb_pkg::EMB_PROD_W-1:0];
  end

endmodule
`default_nettype wire

//--- tb/emb_fab_acc.sv
// Purpose: Fabric-side accumulator that sums the block's products.
// Assumes: Product is taken on i_clk; no overflow handling.
// Notes:   Stands for the logic outside the block that does any adding.
`timescale 1ns/100ps
`default_nettype none
module emb_fab_acc
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_acc_en,
  input  wire logic [35:0] i_product,
  output logic      [39:0] o_acc
);
  logic [39:0] acc_r;
  logic [39:0] acc_nxt;

  // Sum lives outside; the block only multiplies
  always_comb
  begin
    acc_nxt = acc_r;
    if (i_acc_en)
      acc_nxt = acc_r + {4'h0, i_product};
  end

  // Plain register stage
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      acc_r <= 40'h0;
    else
      acc_r <= acc_nxt;
  end

  assign o_acc = acc_r;
endmodule
`default_nettype wire

//--- tb/emb_mult_checker.sv
// Purpose: Port-level assertions for the multiplier block.
// Assumes: One clock domain, synchronous reset.
// Notes:   Control register is hidden, so product checks use reset state.
`timescale 1ns/100ps
`default_nettype none
module emb_mult_checker
(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic [17:0] i_op_a,
  input wire logic [17:0] i_op_b,
  input wire logic        i_sign_a,
  input wire logic        i_sign_b,
  input wire logic [35:0] o_product,
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready
);
  default clocking cb @(posedge i_clk); endclocking

  // High once an edge has passed in reset; before that the control word is unknown
  logic rst_seen_r = 1'b0;
  always_ff @(posedge i_clk)
    rst_seen_r <= i_sys_rst;

  // Reset state is bypass and unsigned, so product is plain a*b
  AST_BYPASS_UNSIGNED: assert property (i_sys_rst && rst_seen_r && !i_sign_a
    && !i_sign_b |-> o_product == 36'(i_op_a) * 36'(i_op_b)) else $error("reset product wrong");
  AST_RST_IDLE: assert property (i_sys_rst |=> !o_s_axi_bvalid && !o_s_axi_rvalid
    && !o_s_axi_arready) else $error("bus not idle in reset");
  AST_B_HOLD: assert property (disable iff (i_sys_rst) o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped");
  AST_R_HOLD: assert property (disable iff (i_sys_rst) o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read answer dropped");
  AST_R_NEXT: assert property (disable iff (i_sys_rst) i_s_axi_arvalid && o_s_axi_arready
    |=> o_s_axi_rvalid) else $error("read answer late");
  AST_AR_BLOCK: assert property (disable iff (i_sys_rst) o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while answer pending");
  // Both channels taken together: answer exactly two edges later
  AST_B_LAT: assert property (disable iff (i_sys_rst) i_s_axi_awvalid && o_s_axi_awready
    && i_s_axi_wvalid && o_s_axi_wready |=> !o_s_axi_bvalid ##1 o_s_axi_bvalid)
    else $error("write answer latency");
  AST_W_BLOCK: assert property (disable iff (i_sys_rst) o_s_axi_bvalid
    |-> !o_s_axi_awready && !o_s_axi_wready) else $error("write taken while answer pending");
endmodule

bind emb_mult_top emb_mult_checker i_emb_mult_checker (.i_clk, .i_sys_rst, .i_op_a, .i_op_b,
  .i_sign_a, .i_sign_b, .o_product, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
  .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid,
  .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready);
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench for the multiplier block.
// Assumes: Bench drives inputs by NBA at or 1 ns after a rising edge, except i_aclr, raised by blocking assignment.
// Notes:   Expected products come from a local signed/unsigned model in t_wide and t_dual, elsewhere from fixed constants.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_aclr = 1'b0, i_clk_en = 1'b1;
  logic [17:0] i_op_a = 18'h00003, i_op_b = 18'h00005;
  logic        i_sign_a = 1'b0, i_sign_b = 1'b0, acc_en = 1'b0;
  logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata;
  logic [3:0]  i_s_axi_wstrb = 4'hF;
  logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic [35:0] o_product;
  logic [39:0] acc;
  int          bad_count = 0;
  int          check_count = 0;

  emb_mult_top i_emb_mult_top (.i_clk, .i_sys_rst, .i_aclr, .i_clk_en, .i_op_a, .i_op_b,
    .i_sign_a, .i_sign_b, .o_product, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready);
  emb_fab_acc i_emb_fab_acc (.i_clk, .i_sys_rst, .i_acc_en(acc_en), .i_product(o_product),
    .o_acc(acc));

  // 250 MHz clock
  always #2 i_clk = ~i_clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hang;
    bad_count++;
    $display("[FAIL] t=%0t bus wait ran out", $time);
    report_and_stop();
  endtask

  // Reference product; w is the lane width, sign taken from bit w-1
  function automatic logic [35:0] mulw(input logic [17:0] a, input logic [17:0] b,
                                       input logic sa, input logic sb, input int w);
    longint x;
    longint y;
    x = (sa && a[w-1]) ? longint'(a) - (longint'(1) << w) : longint'(a);
    y = (sb && b[w-1]) ? longint'(b) - (longint'(1) << w) : longint'(b);
    return 36'(x * y);
  endfunction

  // Write; answer accepted only after slow cycles to stretch the hold
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                     input int slow);
    int n;
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= (slow == 0);
    for (n = 0; n < 50; n++)
    begin
      @(posedge i_clk);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (i_s_axi_bready && o_s_axi_bvalid) break;
      if (n == slow) i_s_axi_bready <= 1'b1;
    end
    i_s_axi_bready <= 1'b0;
    if (n == 50) hang();
    chk({34'h0, o_s_axi_bresp}, {34'h0, er});
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                     input int slow);
    int n;
    @(posedge i_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= (slow == 0);
    for (n = 0; n < 50; n++)
    begin
      @(posedge i_clk);
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      if (i_s_axi_rready && o_s_axi_rvalid) break;
      if (n == slow) i_s_axi_rready <= 1'b1;
    end
    i_s_axi_rready <= 1'b0;
    if (n == 50) hang();
    chk({4'h0, o_s_axi_rdata}, {4'h0, ed});
    chk({34'h0, o_s_axi_rresp}, {34'h0, er});
  endtask

  // Operands land just after an edge, then settle for 1 ns
  task automatic put(input logic [17:0] a, input logic [17:0] b, input logic sa,
                     input logic sb);
    @(posedge i_clk);
    i_op_a <= a;
    i_op_b <= b;
    i_sign_a <= sa;
    i_sign_b <= sb;
    #1;
  endtask

  task automatic t_regs;
    axr(emb_pkg::EMB_OFF_CTRL, emb_pkg::EMB_CTRL_RST, emb_pkg::EMB_RESP_OKAY, 3);
    axw(emb_pkg::EMB_OFF_OPA, 32'hFFFF_FFFF, emb_pkg::EMB_RESP_OKAY, 3);
    axr(emb_pkg::EMB_OFF_OPA, emb_pkg::EMB_OPER_MASK, emb_pkg::EMB_RESP_OKAY, 0);
    axw(8'h18, 32'h1, emb_pkg::EMB_RESP_SLVERR, 0);
    axr(8'h18, emb_pkg::EMB_ZERO_WORD, emb_pkg::EMB_RESP_SLVERR, 0);
    // Software operands, result words, and a dropped write to a read-only word
    axw(emb_pkg::EMB_OFF_OPB, 32'h0003_FFFF, emb_pkg::EMB_RESP_OKAY, 0);
    axw(emb_pkg::EMB_OFF_CTRL, 32'h0000_0020, emb_pkg::EMB_RESP_OKAY, 0);
    axw(emb_pkg::EMB_OFF_RES_LO, 32'h0000_0001, emb_pkg::EMB_RESP_OKAY, 0);
    axr(emb_pkg::EMB_OFF_RES_LO, 32'hFFF8_0001, emb_pkg::EMB_RESP_OKAY, 0);
    axr(emb_pkg::EMB_OFF_RES_HI, 32'h0000_000F, emb_pkg::EMB_RESP_OKAY, 0);
    chk(o_product, 36'hFFFF80001);
    axw(emb_pkg::EMB_OFF_CTRL, emb_pkg::EMB_CTRL_RST, emb_pkg::EMB_RESP_OKAY, 0);
    $display("t_regs done");
  endtask

  // Wide mode, all four sign combinations from the pins, output bypassed
  task automatic t_wide;
    for (int k = 0; k < 4; k++)
    begin
      put(18'h3FFFF, 18'h20000, k[0], k[1]);
      chk(o_product, mulw(18'h3FFFF, 18'h20000, k[0], k[1], 18));
    end
    $display("t_wide done");
  endtask

  // Dual mode, signs from control bits, lanes independent
  task automatic t_dual;
    logic [35:0] lo;
    logic [35:0] hi;
    logic [31:0] c;
    for (int k = 0; k < 2; k++)
    begin
      c = (k == 0) ? 32'h1 : 32'h7;
      axw(emb_pkg::EMB_OFF_CTRL, c, emb_pkg::EMB_RESP_OKAY, 0);
      put({9'h100, 9'h1FF}, {9'h0FF, 9'h002}, 1'b0, 1'b0);
      axr(emb_pkg::EMB_OFF_STATUS, c, emb_pkg::EMB_RESP_OKAY, 0);
      lo = mulw(18'h001FF, 18'h00002, c[1], c[2], 9);
      hi = mulw(18'h00100, 18'h000FF, c[1], c[2], 9);
      chk(o_product, {hi[17:0], lo[17:0]});
    end
    $display("t_dual done");
  endtask

  // Registered paths: latency, enable freeze, asynchronous clear
  task automatic t_pipe;
    axw(emb_pkg::EMB_OFF_CTRL, 32'h18, emb_pkg::EMB_RESP_OKAY, 0);
    put(18'h00011, 18'h00013, 1'b0, 1'b0);
    repeat (3) @(posedge i_clk);
    put(18'h3FFFF, 18'h00100, 1'b0, 1'b0);
    @(posedge i_clk);
    #1 chk(o_product, 36'h000000143);
    @(posedge i_clk);
    #1 chk(o_product, 36'h003FFFF00);
    i_clk_en <= 1'b0;
    put(18'h00002, 18'h00003, 1'b0, 1'b0);
    repeat (3) @(posedge i_clk);
    #1 chk(o_product, 36'h003FFFF00);
    i_aclr = 1'b1;
    #1 chk(o_product, 36'h0);
    @(posedge i_clk);
    i_aclr <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 chk(o_product, 36'h0);
    i_clk_en <= 1'b1;
    @(posedge i_clk);
    #1 chk(o_product, 36'h0);
    @(posedge i_clk);
    #1 chk(o_product, 36'h6);
    axw(emb_pkg::EMB_OFF_CTRL, 32'h8, emb_pkg::EMB_RESP_OKAY, 0);
    put(18'h00007, 18'h00009, 1'b0, 1'b0);
    chk(o_product, 36'h6);
    @(posedge i_clk);
    #1 chk(o_product, 36'h3F);
    $display("t_pipe done");
  endtask

  // Products summed outside the block over three cycles
  task automatic t_acc;
    axw(emb_pkg::EMB_OFF_CTRL, emb_pkg::EMB_CTRL_RST, emb_pkg::EMB_RESP_OKAY, 0);
    put(18'h01000, 18'h00100, 1'b0, 1'b0);
    acc_en <= 1'b1;
    repeat (3) @(posedge i_clk);
    acc_en <= 1'b0;
    #1 chk(acc[35:0], 36'h000300000);
    $display("t_acc done");
  endtask

  initial
  begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    t_regs();
    t_wide();
    t_dual();
    t_pipe();
    t_acc();
    report_and_stop();
  end
endmodule
`default_nettype wire
